// ===== test/lswreg_host.sv
// host side of the register port: single-byte reads and writes
// assumes the bench pops exp_q once for every reg_ack pulse
module lswreg_host (
   input wire logic ref_clk, // bench clock
   output logic [7:0] reg_addr, // register address
   output logic [7:0] reg_wdata, // write data
   output logic reg_write, // write strobe
   output logic reg_read // read strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   // -------------------------------------------------------------
   // expected answers, bit 8 set when read data is to be compared
   // -------------------------------------------------------------
   logic [8:0] exp_q[$];
   // idle levels from time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   // one access: strobe for one cycle, note the expectation first
   task automatic access(input logic wr, input logic [7:0] a,
      input logic [7:0] d, input logic [8:0] e);
      @(negedge ref_clk);
      exp_q.push_back(e);
      reg_addr = a;
      reg_wdata = d;
      reg_write = wr;
      reg_read = !wr;
      @(negedge ref_clk);
      reg_write = 1'b0;
      reg_read = 1'b0;
      // released lines must not keep looking like a valid request
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : access
endmodule : lswreg_host

// ===== test/tb.sv
// self-checking bench for the load switch register bank
// assumes STEP_CYCLES is shortened to 4 cycles per delay step
`include "lswreg_defines.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import lswreg_pkg::*;
   // -------------------------------------------------------------
   // design connections
   // -------------------------------------------------------------
   logic ref_clk, resetn, reg_write, reg_read, reg_ack;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   lswreg_status_type sense_pins; // analog status drive
   lswreg_power_type power_state; // chip power state drive
   logic seq_enable, aux_input_pin, switch_on, reset_output_n;
   logic irq_request, general_pin_two_o, general_pin_two_oe_n;
   logic [1:0] bypass_current_limit_sel, gate_drive_strength;
   logic reg_one_limit_boost, reg_two_limit_boost;
   logic reg_one_switch_mode, reg_two_switch_mode;
   logic buck_two_reference_select, dynamic_voltage_scaling;
   int err_count = 0; // mismatches
   int checks_done = 0; // comparisons
   int c; // cycles waited
   logic [8:0] e; // popped expectation
   logic [7:0] d [7]; // values written per register
   logic [7:0] adr [7]; // register offsets
   lswreg_top #(.STEP_CYCLES(4)) lswreg_top_inst (.ref_clk, .resetn,
      .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .reg_ack,
      .sense_pins, .power_state, .seq_enable, .aux_input_pin, .switch_on,
      .reset_output_n, .irq_request, .general_pin_two_o,
      .general_pin_two_oe_n, .bypass_current_limit_sel,
      .gate_drive_strength, .reg_one_limit_boost, .reg_two_limit_boost,
      .reg_one_switch_mode, .reg_two_switch_mode,
      .buck_two_reference_select, .dynamic_voltage_scaling);
   lswreg_host lswreg_host_inst (.ref_clk, .reg_addr, .reg_wdata,
      .reg_write, .reg_read);
   // 250 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // -------------------------------------------------------------
   // checking and reporting
   // -------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] x);
      checks_done++;
      if (got !== x) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, x);
      end
   endtask : chk
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      lswreg_host_inst.access(1'b1, a, v, 9'h000);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      lswreg_host_inst.access(1'b0, a, 8'h00, {1'b1, x});
   endtask : rd
   // input synchroniser needs four edges, leave margin
   task automatic settle;
      repeat (8) @(negedge ref_clk);
   endtask : settle
   // bounded wait on the switch level; running out ends the run
   task automatic wait_sw(input logic v, input int n);
      c = 0;
      while (switch_on !== v && c < n) begin
         @(negedge ref_clk);
         c++;
      end
      if (switch_on !== v) begin
         err_count++;
         end_of_test;
      end
   endtask : wait_sw
   // answer monitor: every ack takes the oldest note off the queue
   always @(negedge ref_clk) begin
      if (reg_ack === 1'b1) begin
         if (lswreg_host_inst.exp_q.size() == 0) begin
            chk(8'h01, 8'h00);
         end else begin
            e = lswreg_host_inst.exp_q.pop_front();
            if (e[8]) chk(reg_rdata, e[7:0]);
         end
      end
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      end_of_test;
   end
   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      adr = '{8'he5, 8'he6, 8'he7, 8'he8, 8'he9, 8'heb, 8'hec};
      sense_pins = 2'b10;
      power_state = 2'b00;
      seq_enable = 1'b0;
      aux_input_pin = 1'b0;
      resetn = 1'b0;
      void'($urandom(32'hd04188dc));
      repeat (5) @(negedge ref_clk);
      resetn = 1'b1;
      settle;
      // reset image, live power-good in bit 5, unmapped reads 00
      rd(8'he5, 8'h20);
      rd(8'he6, 8'h20);
      rd(8'he7, 8'h40);
      rd(8'he8, 8'h00);
      rd(8'he9, 8'h08);
      rd(8'heb, 8'h00);
      rd(8'hec, 8'h1c);
      rd(8'hea, 8'h00);
      $display("test reset values done");
      // random read-back of the writable registers
      repeat (3) begin
         for (int k = 1; k < 7; k++) begin
            d[k] = 8'($urandom);
            wr(adr[k], d[k]);
            rd(adr[k], d[k]);
         end
         chk({bypass_current_limit_sel, gate_drive_strength, 4'h0},
            {d[1][7:4], 4'h0});
         chk({reg_one_limit_boost, reg_two_limit_boost}, d[5][4:3]);
         chk({reg_one_switch_mode, reg_two_switch_mode}, d[6][5:4]);
         chk(buck_two_reference_select, d[6][0]);
      end
      wr(8'he5, 8'hff);
      rd(8'he5, 8'h2e);
      for (int k = 0; k < 7; k++) wr(adr[k], 8'h00);
      $display("test register access done");
      // live status and interrupt masking
      sense_pins = 2'b01;
      settle;
      rd(8'he5, 8'h10);
      chk(irq_request, 1'b1);
      wr(8'he5, 8'h02);
      sense_pins = 2'b00;
      settle;
      rd(8'he5, 8'h02);
      chk(irq_request, 1'b0);
      sense_pins = 2'b11;
      settle;
      rd(8'he5, 8'h32);
      chk(irq_request, 1'b1);
      sense_pins = 2'b10;
      wr(8'he5, 8'h00);
      $display("test status done");
      // sequenced enable with off delay and reset link
      wr(8'he8, 8'h08);
      wr(8'he9, 8'h04);
      seq_enable = 1'b1;
      wait_sw(1'b1, 12);
      @(negedge ref_clk);
      chk(reset_output_n, 1'b1);
      seq_enable = 1'b0;
      wait_sw(1'b0, 40);
      chk(c inside {[12:16]}, 1'b1);
      settle;
      chk(reset_output_n, 1'b0);
      wr(8'he8, 8'h00);
      seq_enable = 1'b1;
      wait_sw(1'b1, 12);
      seq_enable = 1'b0;
      wait_sw(1'b0, 20);
      chk(c inside {[3:8]}, 1'b1);
      // latch-on keeps the switch after the input drops
      wr(8'he6, 8'h02);
      seq_enable = 1'b1;
      wait_sw(1'b1, 12);
      seq_enable = 1'b0;
      settle;
      chk(switch_on, 1'b1);
      resetn = 1'b0;
      repeat (3) @(negedge ref_clk);
      resetn = 1'b1;
      settle;
      chk(switch_on, 1'b0);
      $display("test sequencing done");
      // direct, sleep, deep sleep and auxiliary control
      wr(8'he7, 8'h90);
      wait_sw(1'b1, 12);
      power_state = 2'b10;
      wait_sw(1'b0, 20);
      power_state = 2'b01;
      wait_sw(1'b1, 20);
      wr(8'he7, 8'h88);
      wait_sw(1'b0, 20);
      wr(8'he7, 8'h20);
      power_state = 2'b00;
      aux_input_pin = 1'b1;
      wait_sw(1'b1, 20);
      aux_input_pin = 1'b0;
      wait_sw(1'b0, 20);
      $display("test switch control done");
      // pin two pull-down and voltage scaling
      wr(8'hec, 8'h80);
      power_state = 2'b10;
      settle;
      chk({general_pin_two_oe_n, general_pin_two_o}, 2'b00);
      power_state = 2'b01;
      settle;
      chk(general_pin_two_oe_n, 1'b1);
      wr(8'hec, 8'h40);
      settle;
      chk(general_pin_two_oe_n, 1'b0);
      wr(8'heb, 8'h06);
      settle;
      chk(dynamic_voltage_scaling, 1'b0);
      power_state = 2'b10;
      settle;
      chk(dynamic_voltage_scaling, 1'b1);
      power_state = 2'b00;
      wr(8'heb, 8'h05);
      settle;
      chk(dynamic_voltage_scaling, 1'b1);
      wr(8'heb, 8'h01);
      settle;
      chk(dynamic_voltage_scaling, 1'b0);
      $display("test pin and scaling done");
      chk(8'(lswreg_host_inst.exp_q.size()), 8'h00);
      end_of_test;
   end
endmodule : tb

// ===== verilog/lswreg_defines.svh
// register offsets, field positions, reset values and timing counts
// assumes a byte-addressed register port fed by an i2c slave elsewhere
`ifndef LSWREG_DEFINES_SVH
`define LSWREG_DEFINES_SVH
// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define LSW_ADDR_STATUS_MASK 8'he5
`define LSW_ADDR_DRIVE_CFG 8'he6
`define LSW_ADDR_ENABLE_CFG 8'he7
`define LSW_ADDR_OFF_DELAY 8'he8
`define LSW_ADDR_RESET_SEQ 8'he9
`define LSW_ADDR_SCALE_BOOST 8'heb
`define LSW_ADDR_SLEEP_MODE 8'hec
// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define LSW_RST_STATUS_MASK 8'h00
`define LSW_RST_DRIVE_CFG 8'h20
`define LSW_RST_ENABLE_CFG 8'h40
`define LSW_RST_OFF_DELAY 8'h00
`define LSW_RST_RESET_SEQ 8'h08
`define LSW_RST_SCALE_BOOST 8'h00
`define LSW_RST_SLEEP_MODE 8'h1c
// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define LSW_BIT_PGOOD 5
`define LSW_BIT_ILIM 4
`define LSW_BIT_PGOOD_MSK 1
`define LSW_BIT_ILIM_MSK 0
`define LSW_MASK_WR_BITS 8'h0e
`define LSW_MASK_FIXED_BITS 8'h0c
`define LSW_BIT_LATCH 1
`define LSW_BIT_DIRECT 7
`define LSW_BIT_AUX 5
`define LSW_BIT_SLEEP 4
`define LSW_BIT_DSLEEP 3
`define LSW_BIT_RSTLINK 2
`define LSW_BIT_R1BOOST 4
`define LSW_BIT_R2BOOST 3
`define LSW_BIT_SCALE_EN 2
`define LSW_BIT_SCALE_SRC 1
`define LSW_BIT_SCALE_REQ 0
`define LSW_BIT_SLP_PD 7
`define LSW_BIT_DSLP_PD 6
`define LSW_BIT_R1MODE 5
`define LSW_BIT_R2MODE 4
`define LSW_BIT_B2REF 0
// ------------------------------------------------------------------
// timing: turn-off delay step 0.25 ms at 250 MHz
// ------------------------------------------------------------------
`define LSW_CLK_MHZ 250
`define LSW_STEP_US 250
`define LSW_STEP_CYCLES (`LSW_STEP_US * `LSW_CLK_MHZ)
`endif

// ===== verilog/lswreg_pkg.sv
// types shared by the load switch register bank
// assumes nothing beyond the defines header
package lswreg_pkg;
   // live analog status, one group
   typedef struct packed {
      logic power_good; // switch output above threshold
      logic current_limit; // switch in current limit
   } lswreg_status_type;
   // power state of the chip
   typedef struct packed {
      logic sleep; // chip in sleep
      logic deep_sleep; // chip in deep sleep
   } lswreg_power_type;
   // switch sequencer states
   typedef enum logic [1:0] {
      LSWREG_OFF,
      LSWREG_ON,
      LSWREG_DELAY
   } lswreg_state_type;
endpackage : lswreg_pkg

// ===== verilog/lswreg_top.sv
// load switch one register bank and enable sequencer
// assumes a byte register port driven by an i2c slave on ref_clk
`include "lswreg_defines.svh"

// Contract
// - live power-good bit for switch one
// - live current-limit bit for switch one
// - power-good mask blocks its interrupt only
// - current-limit mask bit is read-only zero, never blocks its interrupt
// - two-bit buck one bypass current limit
// - two-bit gate drive strength select
// - latch-on keeps switch on after input
// - direct enable turns switch on
// - auxiliary input may switch it
// - sleep-off bit turns switch off
// - deep-sleep-off bit turns switch off
// - off delay equals field times 0.25 ms
// - reset link pulls reset output low
// - regulator boost bits raise limit 12%
// - bus scaling enable bit
// - source select: scaling upon sleep
// - software request enters scaling mode
// - sleep pulldown drives pin two low
// - deep sleep pulldown drives pin low
// - regulator mode bits select switch
// - buck two reference select bit
module lswreg_top #(
   parameter int STEP_CYCLES = `LSW_STEP_CYCLES // cycles per 0.25 ms
) (
   input wire logic ref_clk, // 250 MHz clock
   input wire logic resetn, // async reset, low active
   input wire logic [7:0] reg_addr, // register byte address
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_write, // one-cycle write strobe
   input wire logic reg_read, // one-cycle read strobe
   output logic [7:0] reg_rdata, // read data, registered
   output logic reg_ack, // read or write done
   input wire lswreg_pkg::lswreg_status_type sense_pins, // analog pins
   input wire lswreg_pkg::lswreg_power_type power_state, // chip state
   input wire logic seq_enable, // sequenced input level
   input wire logic aux_input_pin, // auxiliary pin level
   output logic switch_on, // load switch gate enable
   output logic reset_output_n, // reset pin, low active
   output logic irq_request, // unmasked event level
   output logic general_pin_two_o, // pin two drive value
   output logic general_pin_two_oe_n, // pin two enable, low drives
   output logic [1:0] bypass_current_limit_sel, // buck one limit
   output logic [1:0] gate_drive_strength, // gate drive select
   output logic reg_one_limit_boost, // regulator one +12%
   output logic reg_two_limit_boost, // regulator two +12%
   output logic reg_one_switch_mode, // regulator one as switch
   output logic reg_two_switch_mode, // regulator two as switch
   output logic buck_two_reference_select, // 0.8 V when set
   output logic dynamic_voltage_scaling // scaling mode active
);
   import lswreg_pkg::*;

   // ------------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------------
   logic [7:0] status_mask; // writable part of 0xe5
   logic [7:0] drive_cfg; // 0xe6
   logic [7:0] enable_cfg; // 0xe7
   logic [7:0] off_delay; // 0xe8
   logic [7:0] reset_seq; // 0xe9
   logic [7:0] scale_boost; // 0xeb
   logic [7:0] sleep_mode; // 0xec

   // ------------------------------------------------------------------
   // pin synchronisers, three stages, change when stages 2 and 3 agree
   // ------------------------------------------------------------------
   localparam int NSYNC = 6;
   logic [NSYNC-1:0] raw_in; // asynchronous pin levels
   logic [NSYNC-1:0] sync1; // first stage, read only by sync2
   logic [NSYNC-1:0] sync2; // second stage
   logic [NSYNC-1:0] sync3; // third stage
   logic [NSYNC-1:0] clean; // filtered levels

   assign raw_in = {sense_pins.power_good, sense_pins.current_limit,
                    power_state.sleep, power_state.deep_sleep,
                    seq_enable, aux_input_pin};

   // a level is accepted only once two late stages agree
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
               sync1[gi] <= 1'b0;
               sync2[gi] <= 1'b0;
               sync3[gi] <= 1'b0;
               clean[gi] <= 1'b0;
            end else begin
               sync1[gi] <= raw_in[gi];
               sync2[gi] <= sync1[gi];
               sync3[gi] <= sync2[gi];
               if (sync2[gi] == sync3[gi]) begin
                  clean[gi] <= sync3[gi];
               end
            end
         end
      end
   endgenerate

   logic pgood_live; // filtered power good
   logic ilim_live; // filtered current limit
   logic sleep_live; // filtered sleep
   logic dsleep_live; // filtered deep sleep
   logic seq_live; // filtered sequenced input
   logic aux_live; // filtered auxiliary input
   assign {pgood_live, ilim_live, sleep_live, dsleep_live,
           seq_live, aux_live} = clean;

   // ------------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------------
   // address match helper, used by both read and write decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction : hit

   // status bits and the read-only mask bit are never written
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         status_mask <= `LSW_RST_STATUS_MASK;
         drive_cfg <= `LSW_RST_DRIVE_CFG;
         enable_cfg <= `LSW_RST_ENABLE_CFG;
         off_delay <= `LSW_RST_OFF_DELAY;
         reset_seq <= `LSW_RST_RESET_SEQ;
         scale_boost <= `LSW_RST_SCALE_BOOST;
         sleep_mode <= `LSW_RST_SLEEP_MODE;
      end else if (reg_write) begin
         if (hit(reg_addr, `LSW_ADDR_STATUS_MASK)) begin
            // only bits 3..1 store; others fixed
            status_mask <= reg_wdata & `LSW_MASK_WR_BITS;
         end else if (hit(reg_addr, `LSW_ADDR_DRIVE_CFG)) begin
            drive_cfg <= reg_wdata;
         end else if (hit(reg_addr, `LSW_ADDR_ENABLE_CFG)) begin
            enable_cfg <= reg_wdata;
         end else if (hit(reg_addr, `LSW_ADDR_OFF_DELAY)) begin
            off_delay <= reg_wdata;
         end else if (hit(reg_addr, `LSW_ADDR_RESET_SEQ)) begin
            reset_seq <= reg_wdata;
         end else if (hit(reg_addr, `LSW_ADDR_SCALE_BOOST)) begin
            scale_boost <= reg_wdata;
         end else if (hit(reg_addr, `LSW_ADDR_SLEEP_MODE)) begin
            sleep_mode <= reg_wdata;
         end
      end
   end

   // ------------------------------------------------------------------
   // register reads
   // ------------------------------------------------------------------
   logic [7:0] status_view; // live 0xe5 image
   always_comb begin
      status_view = status_mask;
      status_view[`LSW_BIT_PGOOD] = pgood_live;
      status_view[`LSW_BIT_ILIM] = ilim_live;
   end

   // unmapped addresses read zero
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         if (hit(reg_addr, `LSW_ADDR_STATUS_MASK)) begin
            reg_rdata <= status_view;
         end else if (hit(reg_addr, `LSW_ADDR_DRIVE_CFG)) begin
            reg_rdata <= drive_cfg;
         end else if (hit(reg_addr, `LSW_ADDR_ENABLE_CFG)) begin
            reg_rdata <= enable_cfg;
         end else if (hit(reg_addr, `LSW_ADDR_OFF_DELAY)) begin
            reg_rdata <= off_delay;
         end else if (hit(reg_addr, `LSW_ADDR_RESET_SEQ)) begin
            reg_rdata <= reset_seq;
         end else if (hit(reg_addr, `LSW_ADDR_SCALE_BOOST)) begin
            reg_rdata <= scale_boost;
         end else if (hit(reg_addr, `LSW_ADDR_SLEEP_MODE)) begin
            reg_rdata <= sleep_mode;
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   // one-cycle acknowledge after any strobe
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_ack <= 1'b0;
      end else begin
         reg_ack <= reg_read | reg_write;
      end
   end

   // ------------------------------------------------------------------
   // interrupt gating
   // ------------------------------------------------------------------
   // status stays live; the mask only blocks the request
   always_comb begin
      irq_request = (~pgood_live & ~status_mask[`LSW_BIT_PGOOD_MSK])
                  | (ilim_live & ~status_mask[`LSW_BIT_ILIM_MSK]);
   end

   // ------------------------------------------------------------------
   // switch enable request
   // ------------------------------------------------------------------
   logic latched; // switch held by latch-on
   logic want_on; // combined on request
   logic sleep_kill; // sleep or deep sleep forces off

   assign sleep_kill = (sleep_live & enable_cfg[`LSW_BIT_SLEEP])
                     | (dsleep_live & enable_cfg[`LSW_BIT_DSLEEP]);

   // latch-on remembers that the sequence once turned it on
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         latched <= 1'b0;
      end else if (!drive_cfg[`LSW_BIT_LATCH] || sleep_kill) begin
         latched <= 1'b0;
      end else if (seq_live) begin
         latched <= 1'b1;
      end
   end

   always_comb begin
      want_on = seq_live | latched;
      if (enable_cfg[`LSW_BIT_DIRECT]) begin
         want_on = 1'b1;
      end
      if (enable_cfg[`LSW_BIT_AUX]) begin
         want_on = want_on | aux_live;
      end
      if (sleep_kill) begin
         want_on = 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // turn-off delay sequencer
   // ------------------------------------------------------------------
   lswreg_state_type state; // sequencer state
   logic [31:0] tick_count; // cycles inside one 0.25 ms step
   logic [5:0] step_count; // steps elapsed
   logic step_tick; // one-cycle step enable
   logic [5:0] delay_steps; // programmed off delay

   assign delay_steps = off_delay[7:2];
   assign step_tick = (tick_count == 32'(STEP_CYCLES - 1));

   // zero delay turns off the cycle after the request falls
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state <= LSWREG_OFF;
         tick_count <= 32'h0;
         step_count <= 6'h00;
      end else begin
         case (state)
            LSWREG_OFF: begin
               if (want_on) begin
                  state <= LSWREG_ON;
               end
            end
            LSWREG_ON: begin
               tick_count <= 32'h0;
               step_count <= 6'h00;
               if (!want_on) begin
                  state <= (delay_steps == 6'h00) ? LSWREG_OFF
                                                  : LSWREG_DELAY;
               end
            end
            LSWREG_DELAY: begin
               if (want_on) begin
                  state <= LSWREG_ON; // request came back
               end else if (step_tick) begin
                  tick_count <= 32'h0;
                  step_count <= step_count + 6'h01;
                  if (step_count + 6'h01 >= delay_steps) begin
                     state <= LSWREG_OFF;
                  end
               end else begin
                  tick_count <= tick_count + 32'h1;
               end
            end
            default: begin
               state <= LSWREG_OFF;
            end
         endcase
      end
   end

   assign switch_on = (state != LSWREG_OFF);

   // ------------------------------------------------------------------
   // reset output, pin two, analog controls
   // ------------------------------------------------------------------
   // low while linked and the switch is off
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reset_output_n <= 1'b0;
      end else begin
         reset_output_n <= ~(reset_seq[`LSW_BIT_RSTLINK] &
                             (state == LSWREG_OFF));
      end
   end

   // pin two is only ever pulled low, never driven high
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         general_pin_two_oe_n <= 1'b1;
      end else begin
         general_pin_two_oe_n <=
            ~((sleep_live & sleep_mode[`LSW_BIT_SLP_PD])
            | (dsleep_live & sleep_mode[`LSW_BIT_DSLP_PD]));
      end
   end
   assign general_pin_two_o = 1'b0;

   // scaling mode follows sleep or the software request
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         dynamic_voltage_scaling <= 1'b0;
      end else begin
         dynamic_voltage_scaling <= scale_boost[`LSW_BIT_SCALE_EN] &
            (scale_boost[`LSW_BIT_SCALE_SRC] ? sleep_live
                                   : scale_boost[`LSW_BIT_SCALE_REQ]);
      end
   end

   assign bypass_current_limit_sel = drive_cfg[7:6];
   assign gate_drive_strength = drive_cfg[5:4];
   assign reg_one_limit_boost = scale_boost[`LSW_BIT_R1BOOST];
   assign reg_two_limit_boost = scale_boost[`LSW_BIT_R2BOOST];
   assign reg_one_switch_mode = sleep_mode[`LSW_BIT_R1MODE];
   assign reg_two_switch_mode = sleep_mode[`LSW_BIT_R2MODE];
   assign buck_two_reference_select = sleep_mode[`LSW_BIT_B2REF];

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_pgood_read_live: assert property (
      reg_read && reg_addr == `LSW_ADDR_STATUS_MASK |=>
         reg_rdata[`LSW_BIT_PGOOD] == $past(pgood_live))
      else $error("power good read not live");
   a_ilim_read_live: assert property (
      reg_read && reg_addr == `LSW_ADDR_STATUS_MASK |=>
         reg_rdata[`LSW_BIT_ILIM] == $past(ilim_live))
      else $error("current limit read not live");
   a_pgood_mask_gate: assert property (
      status_mask[`LSW_BIT_PGOOD_MSK] && !ilim_live |-> !irq_request)
      else $error("masked power good raised irq");
   a_ilim_mask_gate: assert property (
      status_mask[`LSW_BIT_ILIM_MSK] && pgood_live |-> !irq_request)
      else $error("masked current limit raised irq");
   a_direct_on: assert property (
      enable_cfg[`LSW_BIT_DIRECT] && !sleep_kill |=> switch_on)
      else $error("direct enable did not switch on");
   a_sleep_off_zero: assert property (
      sleep_kill && delay_steps == 6'h00 && state == LSWREG_ON
         |=> !switch_on)
      else $error("sleep kill not honoured");
   a_delay_holds: assert property (
      state == LSWREG_ON && !want_on && delay_steps != 6'h00
         |=> switch_on)
      else $error("switch dropped before delay");
   a_reset_link: assert property (
      reset_seq[`LSW_BIT_RSTLINK] && state == LSWREG_OFF
         |=> !reset_output_n)
      else $error("reset output not driven low");
   a_status_no_write: assert property (
      reg_write && reg_addr == `LSW_ADDR_STATUS_MASK |=>
         (status_mask & ~`LSW_MASK_WR_BITS) == 8'h00)
      else $error("read-only bits stored");
   a_pin_two_low: assert property (
      sleep_live && sleep_mode[`LSW_BIT_SLP_PD] |=> !general_pin_two_oe_n)
      else $error("pin two not pulled low");

   c_switch_on: cover property (state == LSWREG_OFF ##1 switch_on);
   c_delay_done: cover property (state == LSWREG_DELAY ##1
                                 state == LSWREG_OFF);
   c_irq: cover property (irq_request);
   c_scaling: cover property (dynamic_voltage_scaling);
endmodule : lswreg_top
